// *** design/cce_params.svh ***
`ifndef CCE_PARAMS_SVH
`define CCE_PARAMS_SVH

// widths of the datapath, instruction word and program counter
`define CCE_DW          16
`define CCE_IW          24
`define CCE_PC_W        23
`define CCE_ID_W        7

// stack pointer register index and byte step per pushed word
`define CCE_SP_IDX      4'hF
`define CCE_STEP        16'h0002

// program counter after reset, vector table base, first interrupt vector
`define CCE_RESET_PC    23'h00_0000
`define CCE_VEC_BASE    23'h00_0004
`define CCE_IRQ_VEC0    8'h08
`define CCE_TRAP_IPL    3'h7

// a full division takes this many instruction cycles, repeat included
`define CCE_DIV_CYCLES  19
`define CCE_DIV_LAST    5'(`CCE_DIV_CYCLES - 2)

// core registers seen in data space (byte addresses)
`define CCE_MAP_SR      16'h0020
`define CCE_MAP_PAGE    16'h0022
`define CCE_MAP_RCNT    16'h0024
`define CCE_MAP_PCL     16'h0026
`define CCE_MAP_PCH     16'h0028
`define CCE_MAP_TOP     16'h002A

// status word fields
`define CCE_SR_PSV_EN   0
`define CCE_SR_PSV_EE   1
`define CCE_SR_IPL_LO   13

`endif

// *** design/cce_pkg.sv ***
package cce_pkg;
   // opcode in instruction bits 23:20
   typedef enum logic [3:0] {
      OP_NOP, OP_ADD, OP_SUB, OP_MOVL, OP_LD, OP_ST, OP_ADDM, OP_MUL,
      OP_DIV, OP_RPT, OP_BRA, OP_CALL, OP_RET, OP_MOVD, OP_RETFIE
   } cce_op_t;

   // sequencer states
   typedef enum logic [2:0] {
      ST_RUN, ST_PUSH_HI, ST_VEC, ST_POP_LO, ST_MOVD2
   } cce_state_t;
endpackage : cce_pkg

// *** design/cce_core.sv ***
`timescale 1ns/1ps
`include "cce_params.svh"
// How it works
// - datapath words are 16 bits, instructions are 24-bit words
// - program counter is 23 bits wide
// - next instruction is fetched while the current one executes
// - most instructions take one cycle; flow changes and double-word moves longer
// - repeat holds an instruction with no overhead; interrupts may break in
// - sixteen 16-bit working registers serve as data, pointer or offset
// - the last working register is the stack pointer for calls and interrupts
// - upper data half maps to program or eeprom space through an 8-bit page
// - inherent, relative, literal, direct, register direct and indirect modes
// - one cycle may read memory, read a register, write memory and fetch
// - 17x17 multiplier: signed, unsigned or mixed, 16-bit or 8-bit operands
// - every multiply completes in one cycle
// - iterative non-restoring divide, 32 or 16 by 16 bits, signed or not
// - a division takes 19 cycles and may be interrupted between any two
// - vectored entry for eight traps and up to 118 interrupt sources
// - each source has one of seven levels used in arbitration
// - core registers are readable in the data map; all but the program counter words are also writable
module cce_core #(
   parameter int N_IRQ = 118
) (
   input  wire logic                      CLOCK,
   input  wire logic                      SYS_RST,
   output logic [`CCE_PC_W-1:0]           PM_ADDR,
   input  wire logic [`CCE_IW-1:0]        PM_RDATA,
   output logic [`CCE_DW-1:0]             DM_RADDR,
   input  wire logic [`CCE_DW-1:0]        DM_RDATA,
   output logic                           DM_WE,
   output logic [`CCE_DW-1:0]             DM_WADDR,
   output logic [`CCE_DW-1:0]             DM_WDATA,
   output logic                           PSV_RD,
   output logic                           PSV_EE,
   output logic [`CCE_PC_W-1:0]           PSV_ADDR,
   input  wire logic [`CCE_DW-1:0]        PSV_RDATA,
   input  wire logic [7:0]                TRAP_REQ,
   input  wire logic [N_IRQ-1:0]          IRQ_REQ,
   input  wire logic [3*N_IRQ-1:0]        IRQ_LEVEL,
   output logic                           INT_ACK,
   output logic [7:0]                     INT_ACK_VEC,
   output cce_pkg::cce_state_t            CORE_STATE
);
   import cce_pkg::*;

   logic [`CCE_DW-1:0]   w_ff [16];
   cce_state_t           state_ff, nxt_state;
   logic [`CCE_PC_W-1:0] pc_ff, ins_pc_ff;
   logic [`CCE_IW-1:0]   ins_ff;
   logic                 ins_vld_ff, int_ff, ack_ff;
   logic [25:0]          ret_ff;
   logic [7:0]           vec_ff, page_ff;
   logic [15:0]          rpt_ff;
   logic [2:0]           ipl_ff;
   logic                 psv_en_ff, psv_ee_ff;
   logic [16:0]          div_r_ff;
   logic [15:0]          div_q_ff, div_d_ff;
   logic                 div_nq_ff, div_nr_ff;
   logic [4:0]           div_cnt_ff;

   // data-space addresses below the top belong to the core itself
   function automatic logic core_hit(input logic [15:0] a);
      return a < `CCE_MAP_TOP;
   endfunction : core_hit

   // highest level wins, lowest index breaks a tie; level 0 never asks
   function automatic logic [9:0] irq_pick(input logic [N_IRQ-1:0] req,
                                           input logic [3*N_IRQ-1:0] lev);
      logic [2:0] best;
      logic [6:0] id;
      best = 3'h0;
      id   = 7'h00;
      for (int i = N_IRQ - 1; i >= 0; i--) begin
         if (req[i] && lev[3*i +: 3] != 3'h0 && lev[3*i +: 3] >= best) begin
            best = lev[3*i +: 3];
            id   = 7'(i);
         end
      end
      return {best, id};
   endfunction : irq_pick

   // instruction fields
   cce_op_t     op;
   logic [3:0]  wd, ws1, ws2;
   logic [1:0]  md;
   assign op  = cce_op_t'(ins_ff[23:20]);
   assign wd  = ins_ff[19:16];
   assign ws1 = ins_ff[15:12];
   assign ws2 = ins_ff[11:8];
   assign md  = ins_ff[7:6];

   // exception arbitration; traps outrank every level
   logic [9:0] pick;
   logic [2:0] trap_idx;
   logic       trap_any, take_int, exec;
   logic [7:0] vec_now;
   logic [2:0] new_ipl;
   assign pick     = irq_pick(IRQ_REQ, IRQ_LEVEL);
   assign trap_any = |TRAP_REQ;
   always_comb begin
      trap_idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (TRAP_REQ[i]) trap_idx = 3'(i);
      end
   end
   assign take_int = state_ff == ST_RUN && (trap_any || pick[9:7] > ipl_ff);
   assign vec_now  = trap_any ? {5'h00, trap_idx} : `CCE_IRQ_VEC0 + {1'b0, pick[6:0]};
   assign new_ipl  = trap_any ? `CCE_TRAP_IPL : pick[9:7];
   assign exec     = state_ff == ST_RUN && ins_vld_ff && !take_int;

   // operands: register direct, literal, indirect, offset, direct address
   logic [15:0] opb, ea, sp, rd_addr, rdata, core_rdata, wr_addr, wr_data;
   logic [22:0] target, ret_pc;
   logic        psv_hit, rd_use, wr_en, cw;
   assign sp  = w_ff[`CCE_SP_IDX];
   assign opb = md[0] ? {12'h000, ws2} : w_ff[ws2];
   always_comb begin
      case (md)
         2'h2:    ea = w_ff[ws1] + {9'h000, ins_ff[5:0], 1'b0};
         2'h3:    ea = {3'h0, ins_ff[11:0], 1'b0};
         default: ea = w_ff[ws1];
      endcase
   end
   assign target = ins_pc_ff + 23'h00_0001 + {{7{ins_ff[15]}}, ins_ff[15:0]};
   assign ret_pc = take_int ? (ins_vld_ff ? ins_pc_ff : pc_ff) : ins_pc_ff + 23'h00_0001;

   // data read port, pops read the word just below the stack pointer
   always_comb begin
      if (state_ff == ST_POP_LO || (exec && (op == OP_RET || op == OP_RETFIE)))
         rd_addr = sp - `CCE_STEP;
      else if (state_ff == ST_MOVD2)
         rd_addr = ea + `CCE_STEP;
      else
         rd_addr = ea;
   end
   assign rd_use = (exec && (op == OP_LD || op == OP_ADDM || op == OP_MOVD ||
                    op == OP_RET || op == OP_RETFIE)) ||
                   state_ff == ST_MOVD2 || state_ff == ST_POP_LO;
   assign psv_hit  = psv_en_ff && rd_addr[15];
   assign DM_RADDR = rd_addr;
   assign PSV_RD   = rd_use && psv_hit;
   assign PSV_EE   = psv_ee_ff;
   assign PSV_ADDR = {1'b0, page_ff, rd_addr[14:1]};

   // core registers answer in data space ahead of memory
   always_comb begin
      core_rdata = 16'h0000;
      if (!rd_addr[5]) core_rdata = w_ff[rd_addr[4:1]];
      else begin
         case (rd_addr)
            `CCE_MAP_SR:   core_rdata = {ipl_ff, 11'h000, psv_ee_ff, psv_en_ff};
            `CCE_MAP_PAGE: core_rdata = {8'h00, page_ff};
            `CCE_MAP_RCNT: core_rdata = rpt_ff;
            `CCE_MAP_PCL:  core_rdata = ins_pc_ff[15:0];
            `CCE_MAP_PCH:  core_rdata = {9'h000, ins_pc_ff[22:16]};
            default:       core_rdata = 16'h0000;
         endcase
      end
   end
   assign rdata = core_hit(rd_addr) ? core_rdata : psv_hit ? PSV_RDATA : DM_RDATA;

   // data write port: pushes, stores and read-modify-write in one cycle
   always_comb begin
      wr_en   = 1'b0;
      wr_addr = ea;
      wr_data = w_ff[wd];
      if (take_int || (exec && op == OP_CALL)) begin
         wr_en   = 1'b1;
         wr_addr = sp;
         wr_data = ret_pc[15:0];
      end else if (state_ff == ST_PUSH_HI) begin
         wr_en   = 1'b1;
         wr_addr = sp;
         wr_data = {ret_ff[25:23], 6'h00, ret_ff[22:16]};
      end else if (exec && op == OP_ST) begin
         wr_en   = 1'b1;
      end else if (exec && op == OP_ADDM) begin
         wr_en   = 1'b1;
         wr_addr = w_ff[wd];
         wr_data = rdata + w_ff[ws2];
      end
   end
   assign cw       = wr_en && core_hit(wr_addr);
   assign DM_WE    = wr_en && !core_hit(wr_addr);
   assign DM_WADDR = wr_addr;
   assign DM_WDATA = wr_data;

   // multiplier: operands extended to 17 bits by the sign mode
   logic [15:0]        mua, mub;
   logic signed [16:0] ma, mb;
   logic signed [33:0] prod;
   assign mua  = ins_ff[5] ? {{8{w_ff[ws1][7]}}, w_ff[ws1][7:0]} : w_ff[ws1];
   assign mub  = ins_ff[5] ? {{8{w_ff[ws2][7]}}, w_ff[ws2][7:0]} : w_ff[ws2];
   assign ma   = {md != 2'h0 && mua[15], ins_ff[5] && md == 2'h0 ? {8'h00, mua[7:0]} : mua};
   assign mb   = {md == 2'h1 && mub[15], ins_ff[5] && md != 2'h1 ? {8'h00, mub[7:0]} : mub};
   assign prod = ma * mb;

   // divide: magnitudes, one non-restoring step per pass, signs at the end
   logic [31:0] dvd, dmag;
   logic [15:0] dsr, quot, remv;
   logic [16:0] dsh, dstep, rfix;
   logic        sgn;
   assign sgn   = md[1];
   assign dvd   = md[0] ? {w_ff[ws1 + 4'h1], w_ff[ws1]} :
                  {{16{sgn && w_ff[ws1][15]}}, w_ff[ws1]};
   assign dmag  = sgn && dvd[31] ? 32'h0000_0000 - dvd : dvd;
   assign dsr   = sgn && w_ff[ws2][15] ? 16'h0000 - w_ff[ws2] : w_ff[ws2];
   assign dsh   = {div_r_ff[15:0], div_q_ff[15]};
   assign dstep = div_r_ff[16] ? dsh + {1'b0, div_d_ff} : dsh - {1'b0, div_d_ff};
   assign rfix  = div_r_ff[16] ? div_r_ff + {1'b0, div_d_ff} : div_r_ff;
   assign quot  = div_nq_ff ? 16'h0000 - div_q_ff : div_q_ff;
   assign remv  = div_nr_ff ? 16'h0000 - rfix[15:0] : rfix[15:0];

   // divider state survives an interrupt so the repeat can resume it
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         div_r_ff   <= 17'h0_0000;
         div_q_ff   <= 16'h0000;
         div_d_ff   <= 16'h0000;
         div_nq_ff  <= 1'b0;
         div_nr_ff  <= 1'b0;
         div_cnt_ff <= 5'h00;
      end else if (exec && op == OP_DIV) begin
         if (div_cnt_ff == 5'h00) begin
            div_r_ff   <= {1'b0, dmag[31:16]};
            div_q_ff   <= dmag[15:0];
            div_d_ff   <= dsr;
            div_nq_ff  <= sgn && (dvd[31] ^ w_ff[ws2][15]);
            div_nr_ff  <= sgn && dvd[31];
            div_cnt_ff <= 5'h01;
         end else if (div_cnt_ff == `CCE_DIV_LAST) begin
            div_cnt_ff <= 5'h00;
         end else begin
            div_r_ff   <= dstep;
            div_q_ff   <= {div_q_ff[14:0], ~dstep[16]};
            div_cnt_ff <= div_cnt_ff + 5'h01;
         end
      end
   end

   // working registers, later writes in this process take priority
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         for (int i = 0; i < 16; i++) w_ff[i] <= 16'h0000;
      end else begin
         if (exec) begin
            case (op)
               OP_ADD:  w_ff[wd] <= w_ff[ws1] + opb;
               OP_SUB:  w_ff[wd] <= w_ff[ws1] - opb;
               OP_MOVL: w_ff[wd] <= ins_ff[15:0];
               OP_LD, OP_MOVD: w_ff[wd] <= rdata;
               OP_MUL: begin
                  w_ff[wd]        <= prod[15:0];
                  w_ff[wd + 4'h1] <= prod[31:16];
               end
               OP_DIV: begin
                  if (div_cnt_ff == `CCE_DIV_LAST) begin
                     w_ff[4'h0] <= quot;
                     w_ff[4'h1] <= remv;
                  end
               end
               default: ;
            endcase
            if ((op == OP_LD || op == OP_ST) && md == 2'h1)
               w_ff[ws1] <= w_ff[ws1] + `CCE_STEP;
         end
         if (state_ff == ST_MOVD2) w_ff[wd + 4'h1] <= rdata;
         if (take_int || (exec && op == OP_CALL) || state_ff == ST_PUSH_HI)
            w_ff[`CCE_SP_IDX] <= sp + `CCE_STEP;
         else if ((exec && (op == OP_RET || op == OP_RETFIE)) || state_ff == ST_POP_LO)
            w_ff[`CCE_SP_IDX] <= sp - `CCE_STEP;
         if (cw && !wr_addr[5]) w_ff[wr_addr[4:1]] <= wr_data;
      end
   end

   // repeat count, priority, window page and control bits
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         rpt_ff    <= 16'h0000;
         ipl_ff    <= 3'h0;
         page_ff   <= 8'h00;
         psv_en_ff <= 1'b0;
         psv_ee_ff <= 1'b0;
      end else begin
         if (exec && op == OP_RPT) rpt_ff <= ins_ff[15:0];
         else if (exec && rpt_ff != 16'h0000) rpt_ff <= rpt_ff - 16'h0001;
         if (take_int) ipl_ff <= new_ipl;
         else if (exec && op == OP_RETFIE) ipl_ff <= rdata[15:13];
         if (cw && wr_addr == `CCE_MAP_SR) begin
            ipl_ff    <= wr_data[15:13];
            psv_en_ff <= wr_data[`CCE_SR_PSV_EN];
            psv_ee_ff <= wr_data[`CCE_SR_PSV_EE];
         end
         if (cw && wr_addr == `CCE_MAP_PAGE) page_ff <= wr_data[7:0];
         if (cw && wr_addr == `CCE_MAP_RCNT) rpt_ff <= wr_data;
      end
   end

   // sequencer
   always_comb begin
      nxt_state = ST_RUN;
      case (state_ff)
         ST_RUN: begin
            if (take_int || (exec && op == OP_CALL)) nxt_state = ST_PUSH_HI;
            else if (exec && (op == OP_RET || op == OP_RETFIE)) nxt_state = ST_POP_LO;
            else if (exec && op == OP_MOVD) nxt_state = ST_MOVD2;
         end
         ST_PUSH_HI: nxt_state = int_ff ? ST_VEC : ST_RUN;
         default:    nxt_state = ST_RUN;
      endcase
   end

   // fetch stalls while an instruction repeats or a sequence runs, except in ST_MOVD2, which fetches
   logic hold, fetch;
   assign hold  = rpt_ff != 16'h0000 || op == OP_BRA || op == OP_CALL ||
                  op == OP_RET || op == OP_RETFIE || op == OP_MOVD;
   assign fetch = (state_ff == ST_RUN && !take_int && !(ins_vld_ff && hold)) ||
                  state_ff == ST_MOVD2;
   assign PM_ADDR = state_ff == ST_VEC ? `CCE_VEC_BASE + {15'h0000, vec_ff} : pc_ff;

   // program counter and prefetch register
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         state_ff   <= ST_RUN;
         pc_ff      <= `CCE_RESET_PC;
         ins_pc_ff  <= `CCE_RESET_PC;
         ins_ff     <= 24'h00_0000;
         ins_vld_ff <= 1'b0;
         ret_ff     <= 26'h000_0000;
         int_ff     <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (fetch) begin
            ins_ff     <= PM_RDATA;
            ins_pc_ff  <= pc_ff;
            pc_ff      <= pc_ff + 23'h00_0001;
            ins_vld_ff <= 1'b1;
         end
         if (take_int) begin
            ret_ff     <= {ipl_ff, ret_pc};
            int_ff     <= 1'b1;
            ins_vld_ff <= 1'b0;
            pc_ff      <= ret_pc;
         end else if (exec && (op == OP_BRA || op == OP_CALL)) begin
            ret_ff     <= {ipl_ff, ret_pc};
            int_ff     <= 1'b0;
            pc_ff      <= target;
            ins_vld_ff <= 1'b0;
         end
         if (state_ff == ST_RUN && ins_vld_ff && !take_int && (op == OP_RET || op == OP_RETFIE))
            ret_ff[22:16] <= rdata[6:0];
         if (state_ff == ST_POP_LO) begin
            pc_ff      <= {ret_ff[22:16], rdata};
            ins_vld_ff <= 1'b0;
         end
         if (state_ff == ST_VEC) pc_ff <= PM_RDATA[22:0];
      end
   end

   // acknowledge one cycle after the decision, vector held for the fetch
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ack_ff <= 1'b0;
         vec_ff <= 8'h00;
      end else begin
         ack_ff <= take_int;
         if (take_int) vec_ff <= vec_now;
      end
   end
   assign INT_ACK     = ack_ff;
   assign INT_ACK_VEC = vec_ff;
   assign CORE_STATE  = state_ff;

   a_pc_step: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      fetch && !take_int && state_ff == ST_RUN && !(exec && op == OP_RPT) |=>
      ins_pc_ff == $past(pc_ff) && ins_vld_ff) else $error("prefetch lost");
   a_pc_width: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      fetch && state_ff == ST_RUN && !take_int |=> pc_ff == $past(pc_ff) + 23'h00_0001)
      else $error("pc did not advance");
   a_rpt_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      exec && rpt_ff != 16'h0000 |=> $stable(ins_pc_ff) && rpt_ff == $past(rpt_ff) - 16'h0001)
      else $error("repeat did not hold");
   a_mul_single: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      exec && op == OP_MUL |=> w_ff[$past(wd)] == $past(prod[15:0]))
      else $error("multiply not done in one cycle");
   a_div_finish: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      exec && op == OP_DIV && div_cnt_ff == `CCE_DIV_LAST |=>
      div_cnt_ff == 5'h00 && w_ff[0] == $past(quot) && w_ff[1] == $past(remv))
      else $error("divide result not written");
   a_int_push: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      take_int |-> DM_WE ##1 state_ff == ST_PUSH_HI && DM_WE && INT_ACK
      ##1 state_ff == ST_VEC) else $error("entry sequence broken");
   a_sp_push: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      take_int |-> ##2 w_ff[15] == $past(w_ff[15], 2) + 16'h0004)
      else $error("stack pointer not advanced");
   a_irq_level: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      take_int && !trap_any |-> pick[9:7] > ipl_ff ##1 ipl_ff == $past(pick[9:7]))
      else $error("priority not honoured");
   a_trap_vec: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      take_int && trap_any |=> INT_ACK_VEC < `CCE_IRQ_VEC0 && ipl_ff == `CCE_TRAP_IPL)
      else $error("trap not vectored first");
   a_movd_two: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      exec && op == OP_MOVD |=> state_ff == ST_MOVD2 ##1 state_ff == ST_RUN)
      else $error("double move length wrong");
   a_psv_map: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      PSV_RD |-> PSV_ADDR[21:14] == page_ff && rd_addr[15] && !DM_WE)
      else $error("window address wrong");
endmodule : cce_core

// *** sim/cce_partner.sv ***
`timescale 1ns/1ps
`include "cce_params.svh"
module cce_partner #(
   parameter int N_IRQ = 4
) (
   input  wire logic                 CLOCK,
   input  wire logic                 SYS_RST,
   input  wire logic [`CCE_PC_W-1:0] PM_ADDR,
   output logic [`CCE_IW-1:0]        PM_RDATA,
   input  wire logic [`CCE_DW-1:0]   DM_RADDR,
   output logic [`CCE_DW-1:0]        DM_RDATA,
   input  wire logic                 DM_WE,
   input  wire logic [`CCE_DW-1:0]   DM_WADDR,
   input  wire logic [`CCE_DW-1:0]   DM_WDATA,
   input  wire logic                 PSV_EE,
   input  wire logic [`CCE_PC_W-1:0] PSV_ADDR,
   output logic [`CCE_DW-1:0]        PSV_RDATA,
   input  wire logic                 INT_ACK,
   input  wire logic [7:0]           RAISE_TRAP,
   input  wire logic [N_IRQ-1:0]     RAISE_IRQ,
   output logic [7:0]                TRAP_REQ,
   output logic [N_IRQ-1:0]          IRQ_REQ
);
   logic [`CCE_IW-1:0] pm [0:63];
   logic [`CCE_DW-1:0] dm [0:255];

   // same-cycle reads, small memories alias upward
   assign PM_RDATA  = pm[PM_ADDR[5:0]];
   assign DM_RDATA  = dm[DM_RADDR[8:1]];
   assign PSV_RDATA = PSV_EE ? ~PSV_ADDR[15:0] : PSV_ADDR[15:0];

   // reset fills a pattern so stale results from an earlier run never pass
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         for (int i = 0; i < 256; i++) dm[i] <= 16'hA5A5;
      end else if (DM_WE) begin
         dm[DM_WADDR[8:1]] <= DM_WDATA;
      end
   end

   // requests hold until acknowledged, then drop one cycle later
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || INT_ACK) begin
         TRAP_REQ <= '0;
         IRQ_REQ  <= '0;
      end else begin
         TRAP_REQ <= TRAP_REQ | RAISE_TRAP;
         IRQ_REQ  <= IRQ_REQ | RAISE_IRQ;
      end
   end
endmodule : cce_partner

// *** sim/cpu_core_execution_bench.sv ***
`timescale 1ns/1ps
`include "cce_params.svh"
module cpu_core_execution_bench;
   import cce_pkg::*;
   localparam int NI = 4;
   logic            clock, sys_rst, dm_we, psv_rd, psv_ee, int_ack;
   logic [22:0]     pm_addr, psv_addr;
   logic [23:0]     pm_rdata;
   logic [15:0]     dm_raddr, dm_rdata, dm_waddr, dm_wdata, psv_rdata;
   logic [7:0]      trap_req, raise_trap, int_ack_vec;
   logic [NI-1:0]   irq_req, raise_irq;
   logic [3*NI-1:0] irq_level;
   cce_state_t      core_state;
   int              num_errors = 0;
   int              n_tests = 0;

   cce_core #(.N_IRQ(NI)) DUT (.CLOCK(clock), .SYS_RST(sys_rst), .PM_ADDR(pm_addr),
      .PM_RDATA(pm_rdata), .DM_RADDR(dm_raddr), .DM_RDATA(dm_rdata), .DM_WE(dm_we),
      .DM_WADDR(dm_waddr), .DM_WDATA(dm_wdata), .PSV_RD(psv_rd), .PSV_EE(psv_ee),
      .PSV_ADDR(psv_addr), .PSV_RDATA(psv_rdata), .TRAP_REQ(trap_req), .IRQ_REQ(irq_req),
      .IRQ_LEVEL(irq_level), .INT_ACK(int_ack), .INT_ACK_VEC(int_ack_vec),
      .CORE_STATE(core_state));
   cce_partner #(.N_IRQ(NI)) mem (.CLOCK(clock), .SYS_RST(sys_rst), .PM_ADDR(pm_addr),
      .PM_RDATA(pm_rdata), .DM_RADDR(dm_raddr), .DM_RDATA(dm_rdata), .DM_WE(dm_we),
      .DM_WADDR(dm_waddr), .DM_WDATA(dm_wdata), .PSV_EE(psv_ee), .PSV_ADDR(psv_addr),
      .PSV_RDATA(psv_rdata), .INT_ACK(int_ack), .RAISE_TRAP(raise_trap),
      .RAISE_IRQ(raise_irq), .TRAP_REQ(trap_req), .IRQ_REQ(irq_req));

   // 50 ns period
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   function automatic logic [23:0] enc(cce_op_t op, logic [3:0] wd, logic [15:0] low);
      return {op, wd, low};
   endfunction : enc

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   // reset held while the program image is rewritten
   task automatic fresh();
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      for (int i = 0; i < 64; i++) mem.pm[i] = '0;
   endtask : fresh

   task automatic run(input int n);
      @(posedge clock);
      sys_rst <= 1'b0;
      repeat (n) @(posedge clock);
      #1;
   endtask : run

   // back-to-back stores must show on consecutive cycles
   task automatic t_alu();
      fresh();
      mem.pm[0] = enc(OP_MOVL, 4'h1, 16'h1234);
      mem.pm[1] = enc(OP_MOVL, 4'h2, 16'h0011);
      mem.pm[2] = enc(OP_ADD, 4'h3, 16'h1200);
      mem.pm[3] = enc(OP_SUB, 4'h4, 16'h1540);
      mem.pm[4] = enc(OP_ST, 4'h3, 16'h00C0);
      mem.pm[5] = enc(OP_ST, 4'h4, 16'h00C1);
      mem.pm[6] = enc(OP_BRA, 4'h0, 16'hFFFF);
      run(5);
      check(dm_we, 1'b1, "first store strobe");
      check(dm_wdata, 16'h1245, "register add");
      @(posedge clock);
      #1;
      check(dm_we, 1'b1, "second store strobe");
      check(dm_waddr, 16'h0182, "store address");
      check(dm_wdata, 16'h122F, "literal subtract");
      $display("test alu done");
   endtask : t_alu

   // product is used by the very next instruction
   task automatic t_mul(input logic [1:0] md, input logic byt, input logic [31:0] exp);
      fresh();
      mem.pm[0] = enc(OP_MOVL, 4'h1, 16'hFFFE);
      mem.pm[1] = enc(OP_MOVL, 4'h2, 16'hFFFD);
      mem.pm[2] = enc(OP_MUL, 4'h4, {8'h12, md, byt, 5'h00});
      mem.pm[3] = enc(OP_ST, 4'h4, 16'h00C0);
      mem.pm[4] = enc(OP_ST, 4'h5, 16'h00C1);
      mem.pm[5] = enc(OP_BRA, 4'h0, 16'hFFFF);
      run(10);
      check({mem.dm[8'hC1], mem.dm[8'hC0]}, exp, "product");
      $display("test mul done mode %b byte %b", md, byt);
   endtask : t_mul

   // repeat plus eighteen passes: the store follows nineteen cycles later
   task automatic t_div(input logic [1:0] md, input logic [15:0] lo, input logic [15:0] hi,
                        input logic [31:0] exp);
      fresh();
      mem.pm[0] = enc(OP_MOVL, 4'h2, lo);
      mem.pm[1] = enc(OP_MOVL, 4'h4, 16'h0007);
      mem.pm[2] = enc(OP_MOVL, 4'h3, hi);
      mem.pm[3] = enc(OP_RPT, 4'h0, 16'h0011);
      mem.pm[4] = enc(OP_DIV, 4'h0, {8'h24, md, 6'h00});
      mem.pm[5] = enc(OP_ST, 4'h0, 16'h00C0);
      mem.pm[6] = enc(OP_ST, 4'h1, 16'h00C1);
      mem.pm[7] = enc(OP_BRA, 4'h0, 16'hFFFF);
      run(22);
      check(dm_we, 1'b0, "store too early");
      @(posedge clock);
      #1;
      check(dm_we, 1'b1, "store after divide");
      repeat (3) @(posedge clock);
      #1;
      check({mem.dm[8'hC1], mem.dm[8'hC0]}, exp, "remainder and quotient");
      $display("test div done mode %b", md);
   endtask : t_div

   // status and page written through the data map, then a load through the window
   task automatic t_psv();
      fresh();
      mem.pm[0] = enc(OP_MOVL, 4'h1, 16'h0001);
      mem.pm[1] = enc(OP_MOVL, 4'h2, 16'h0003);
      mem.pm[2] = enc(OP_MOVL, 4'h3, 16'h8004);
      mem.pm[3] = enc(OP_MOVL, 4'h4, 16'h0020);
      mem.pm[4] = enc(OP_MOVL, 4'h5, 16'h0022);
      mem.pm[5] = enc(OP_ST, 4'h1, 16'h4000);
      mem.pm[6] = enc(OP_ST, 4'h2, 16'h5000);
      mem.pm[7] = enc(OP_LD, 4'h6, 16'h3000);
      mem.pm[8] = enc(OP_ST, 4'h6, 16'h00C0);
      mem.pm[9] = enc(OP_BRA, 4'h0, 16'hFFFF);
      run(8);
      check(psv_rd, 1'b1, "window read strobe");
      check(psv_addr, 23'h00_C002, "window address");
      repeat (3) @(posedge clock);
      #1;
      check(mem.dm[8'hC0], 16'hC002, "window data");
      $display("test psv done");
   endtask : t_psv

   task automatic t_irq(input logic [7:0] trap, input logic [NI-1:0] irq,
                        input logic [7:0] vec, input logic take);
      int k;
      fresh();
      for (int i = 4; i < 16; i++) mem.pm[i] = 24'h00_0014;
      mem.pm[0]  = enc(OP_MOVL, 4'hF, 16'h0100);
      mem.pm[1]  = enc(OP_BRA, 4'h0, 16'hFFFF);
      mem.pm[20] = enc(OP_ST, 4'hF, 16'h00F0);
      mem.pm[21] = enc(OP_BRA, 4'h0, 16'hFFFF);
      run(4);
      @(posedge clock);
      raise_trap <= trap;
      raise_irq  <= irq;
      @(posedge clock);
      raise_trap <= '0;
      raise_irq  <= '0;
      for (k = 0; k < 40 && int_ack !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      if (take && k == 40) begin
         num_errors++;
         wrap_up();
      end
      check(int_ack, take, "acknowledge");
      check(int_ack_vec, take ? vec : 8'h00, "vector");
      if (take) begin
         repeat (10) @(posedge clock);
         #1;
         check(mem.dm[8'h81], 16'h0000, "pushed status word");
         check(mem.dm[8'hF0], 16'h0104, "stack pointer in handler");
      end
      $display("test irq done vec %h", vec);
   endtask : t_irq

   initial begin
      sys_rst    = 1'b1;
      raise_trap = '0;
      raise_irq  = '0;
      irq_level  = 12'h158;
      repeat (8) @(posedge clock);
      t_alu();
      t_mul(2'b00, 1'b0, 32'hFFFB_0006);
      t_mul(2'b01, 1'b0, 32'h0000_0006);
      t_mul(2'b10, 1'b0, 32'hFFFE_0006);
      t_mul(2'b00, 1'b1, 32'h0000_FB06);
      t_div(2'b00, 16'h0064, 16'h0000, 32'h0002_000E);
      t_div(2'b11, 16'hFF9C, 16'hFFFF, 32'hFFFE_FFF2);
      t_psv();
      t_irq(8'h00, 4'b0010, 8'h09, 1'b1);
      t_irq(8'h00, 4'b0110, 8'h0A, 1'b1);
      t_irq(8'h04, 4'b0000, 8'h02, 1'b1);
      t_irq(8'h00, 4'b0001, 8'h08, 1'b0);
      wrap_up();
   end
endmodule : cpu_core_execution_bench
